//--- core/cmc_map.svh
// Register map, field positions and counts of the CAN main mode control block
`ifndef CMC_MAP_SVH
`define CMC_MAP_SVH
`define CMC_AW          12
`define CMC_CTRL_OFF    12'h000
`define CMC_STAT_OFF    12'h004
`define CMC_BOFF_OFF    12'h040
`define CMC_CTRL_RST    32'h00010002
`define CMC_CTRL_WMASK  32'h0001807f
`define CMC_CTRL_SMASK  32'h00008000
`define CMC_B_INIT      0
`define CMC_B_SLEEP     1
`define CMC_B_TXPRI     2
`define CMC_B_RXLOCK    3
`define CMC_B_NORTX     4
`define CMC_B_AWAKE     5
`define CMC_B_ABOFF     6
`define CMC_B_FORCED_CONTROLLER_RESET     15
`define CMC_B_FRZ       16
`define CMC_S_INIT      0
`define CMC_S_SLEEP     1
`define CMC_S_RXLVL     11
`define CMC_BO_TEC_LSB  8
`define CMC_REC_BITS    4'ha
`define CMC_REC_SEQS    8'h7f
`define CMC_TEC_LIMIT   9'h0ff
`define CMC_RESP_OK     2'b00
`define CMC_RESP_ERR    2'b10
`endif

//--- core/cmc_pkg.sv
// Types shared by the CAN main mode control block
`include "cmc_map.svh"
package cmc_pkg;
    typedef enum logic [1:0] {CMC_SLEEP, CMC_INIT, CMC_NORMAL} cmc_mode_type;

    typedef struct packed {
        logic                awvalid;
        logic [`CMC_AW-1:0]  awaddr;
        logic                wvalid;
        logic [31:0]         wdata;
        logic [3:0]          wstrb;
        logic                bready;
        logic                arvalid;
        logic [`CMC_AW-1:0]  araddr;
        logic                rready;
    } cmc_axi_req_type;

    typedef struct packed {
        logic                awready;
        logic                wready;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                arready;
        logic                rvalid;
        logic [31:0]         rdata;
        logic [1:0]          rresp;
    } cmc_axi_rsp_type;

    typedef struct packed {
        logic                tx_priority_by_order;
        logic                rx_fifo_overrun_lock;
        logic                auto_retransmit_disable;
        logic                run_enable;
        logic                controller_reset;
        logic                busoff_flag;
    } cmc_engine_type;

    typedef struct packed {
        logic [31:0]         ctrl;
        cmc_mode_type        mode;
        logic                busoff;
        logic                armed;
        logic [3:0]          rec_bits;
        logic [7:0]          rec_seqs;
        logic                run;
        logic                ctl_rst;
        logic                rx_s1;
        logic                rx_s2;
        logic                rx_prev;
        logic                awready;
        logic                wready;
        logic                bvalid;
        logic [1:0]          bresp;
        logic [`CMC_AW-1:0]  awaddr;
        logic [31:0]         wdata;
        logic [3:0]          wstrb;
        logic                arready;
        logic                rvalid;
        logic [1:0]          rresp;
        logic [31:0]         rdata;
    } cmc_state_type;
endpackage

//--- core/cmc_top.sv
// CAN main mode control: control word, mode machine, bus-off recovery, AXI4-Lite slave
//
// Operation
// R01: Control bit 0 set enters initialization mode; cleared returns to normal.
// R02: Sleep request bit 1 set enters sleep; cleared leaves sleep.
// R03: With auto wake-up, receive activity clears the sleep request by hardware.
// R04: After reset the control word is 0x00010002 and the controller sleeps.
// R05: Transmit priority bit 0 selects ordering by message identifier.
// R06: Transmit priority bit 1 selects chronological order of requests.
// R07: Receive lock bit 0: new message overwrites unread one in full FIFO.
// R08: Receive lock bit 1: new message is discarded, stored content kept.
// R09: Retransmit disable 0: retry automatically until sent successfully.
// R10: Retransmit disable 1: each message is attempted only once.
// R11: Without auto wake-up, software wakes the controller by clearing sleep request.
// R12: With auto wake-up, receive line activity ends sleep mode.
// R13: Auto recovery set: leave bus-off after 128 runs of 11 recessive bits.
// R14: Auto recovery clear: software sets then clears init before recovery counting.
// R15: Writing the software reset bit forces a reset, ending in sleep mode.
// R16: Software reset bit self-clears once applied; software can only set it.
// R17: Debug freeze with core halted stops traffic; registers stay usable.
// R18: Status bit 0 reads one while in initialization mode.
// R19: A status bit reads one while in sleep mode.
// R20: Transmit error count above 255 enters bus-off, sets flag, stops traffic.
// R21: Reserved control bits ignore writes and read zero.
`timescale 1ns/1ps
`default_nettype none
`include "cmc_map.svh"
module cmc_top
    import cmc_pkg::*;
(
    // Clock and reset
    input  wire logic            clk_sys,
    input  wire logic            rst,
    // Register bus
    input  wire cmc_axi_req_type axi_i,
    output cmc_axi_rsp_type      axi_o,
    // Receive pin, protocol engine status and debug halt
    input  wire logic            can_rx,
    input  wire logic            bit_strobe,
    input  wire logic [8:0]      tec,
    input  wire logic            dbg_halt,
    // Engine configuration
    output cmc_engine_type       eng_o
);
    cmc_state_type s;
    cmc_state_type n;
    logic          rx_edge;
    logic          wr_go;
    logic          wr_ctrl;
    logic          hit_w;
    logic          recount;
    logic [31:0]   wv;
    logic [31:0]   base;
    logic [31:0]   stat;
    logic [31:0]   boff;
    logic [31:0]   wbe;

    // Byte lane masks from the latched strobes, so a partial write keeps the other lanes
    for (genvar i = 0; i < 4; i++) begin : g_lane
        assign wbe[8*i +: 8] = {8{s.wstrb[i]}};
    end

    //------------------------------------------------------------------
    // Bus answers and engine configuration
    //------------------------------------------------------------------
    // All of these are plain flop bits of the state record
    assign axi_o.awready = s.awready;
    assign axi_o.wready  = s.wready;
    assign axi_o.bvalid  = s.bvalid;
    assign axi_o.bresp   = s.bresp;
    assign axi_o.arready = s.arready;
    assign axi_o.rvalid  = s.rvalid;
    assign axi_o.rdata   = s.rdata;
    assign axi_o.rresp   = s.rresp;
    assign eng_o.tx_priority_by_order    = s.ctrl[`CMC_B_TXPRI];  // see R05 see R06
    assign eng_o.rx_fifo_overrun_lock    = s.ctrl[`CMC_B_RXLOCK]; // see R07 see R08
    assign eng_o.auto_retransmit_disable = s.ctrl[`CMC_B_NORTX];  // see R09 see R10
    assign eng_o.run_enable              = s.run;
    assign eng_o.controller_reset        = s.ctl_rst;
    assign eng_o.busoff_flag             = s.busoff;

    //------------------------------------------------------------------
    // Next-state logic
    //------------------------------------------------------------------
    always_comb begin
        n = s;
        // Two-flop synchroniser; edges are only taken from the second stage
        n.rx_s1   = can_rx;
        n.rx_s2   = s.rx_s1;
        n.rx_prev = s.rx_s2;
        rx_edge   = s.rx_prev & ~s.rx_s2;

        // Read views
        stat = 32'h0;
        stat[`CMC_S_INIT]  = (s.mode == CMC_INIT);  // see R18
        stat[`CMC_S_SLEEP] = (s.mode == CMC_SLEEP); // see R19
        stat[`CMC_S_RXLVL] = s.rx_s2;
        boff = 32'h0;
        boff[0] = s.busoff;
        boff[`CMC_BO_TEC_LSB +: 9] = tec;

        // Write address and data are taken independently, in either order
        if (axi_i.awvalid && s.awready) begin
            n.awready = 1'b0;
            n.awaddr  = axi_i.awaddr;
        end
        if (axi_i.wvalid && s.wready) begin
            n.wready = 1'b0;
            n.wdata  = axi_i.wdata;
            n.wstrb  = axi_i.wstrb;
        end
        if (s.bvalid && axi_i.bready) begin
            n.bvalid  = 1'b0;
            n.awready = 1'b1;
            n.wready  = 1'b1;
        end
        wr_go   = !s.awready && !s.wready && !s.bvalid;
        hit_w   = ({s.awaddr[`CMC_AW-1:2], 2'b00} == `CMC_CTRL_OFF)
                || ({s.awaddr[`CMC_AW-1:2], 2'b00} == `CMC_STAT_OFF)
                || ({s.awaddr[`CMC_AW-1:2], 2'b00} == `CMC_BOFF_OFF);
        wr_ctrl = wr_go && ({s.awaddr[`CMC_AW-1:2], 2'b00} == `CMC_CTRL_OFF);
        if (wr_go) begin
            n.bvalid = 1'b1;
            n.bresp  = hit_w ? `CMC_RESP_OK : `CMC_RESP_ERR;
        end

        // Hardware wake-up clears the sleep request; a software write
        // in the same cycle is applied on top and so wins
        base = s.ctrl;
        if (s.mode == CMC_SLEEP && s.ctrl[`CMC_B_AWAKE] && rx_edge) begin
            base[`CMC_B_SLEEP] = 1'b0; // see R03 see R12
        end
        wv = (base & ~wbe) | (s.wdata & wbe);
        // Reserved bits never load; reset bit can only be set
        n.ctrl = base;
        if (wr_ctrl) begin
            n.ctrl = (base & ~`CMC_CTRL_WMASK) | (wv & `CMC_CTRL_WMASK)
                   | (base & `CMC_CTRL_SMASK); // see R21 see R16
        end

        // Read channel answers one cycle after the address is taken
        if (axi_i.arvalid && s.arready) begin
            n.arready = 1'b0;
            n.rvalid  = 1'b1;
            n.rresp   = `CMC_RESP_OK;
            case ({axi_i.araddr[`CMC_AW-1:2], 2'b00})
                `CMC_CTRL_OFF: n.rdata = s.ctrl;
                `CMC_STAT_OFF: n.rdata = stat;
                `CMC_BOFF_OFF: n.rdata = boff;
                default: begin
                    n.rdata = 32'h0;
                    n.rresp = `CMC_RESP_ERR;
                end
            endcase
        end
        if (s.rvalid && axi_i.rready) begin
            n.rvalid  = 1'b0;
            n.arready = 1'b1;
        end

        // Mode follows the requests; initialization has precedence
        case (s.ctrl[`CMC_B_SLEEP:`CMC_B_INIT])
            2'h0:    n.mode = CMC_NORMAL;  // see R01 see R02
            2'h2:    n.mode = CMC_SLEEP;   // see R02
            default: n.mode = CMC_INIT;    // see R01
        endcase

        // Bus-off entry and recovery counting on sampled bits
        if (s.busoff && s.ctrl[`CMC_B_INIT]) begin
            n.armed = 1'b1; // see R14
        end
        recount = s.busoff
                && (s.ctrl[`CMC_B_ABOFF] || (s.armed && !s.ctrl[`CMC_B_INIT])); // see R13 see R14
        if (!s.busoff && tec > `CMC_TEC_LIMIT) begin
            n.busoff   = 1'b1; // see R20
            n.armed    = 1'b0;
            n.rec_bits = 4'h0;
            n.rec_seqs = 8'h0;
        end else if (recount && bit_strobe) begin
            if (!s.rx_s2) begin
                n.rec_bits = 4'h0; // Dominant bit breaks the run
            end else if (s.rec_bits != `CMC_REC_BITS) begin
                n.rec_bits = s.rec_bits + 4'h1;
            end else begin
                n.rec_bits = 4'h0;
                n.rec_seqs = s.rec_seqs + 8'h1;
                if (s.rec_seqs == `CMC_REC_SEQS) begin
                    n.busoff   = 1'b0; // see R13
                    n.armed    = 1'b0;
                    n.rec_seqs = 8'h0;
                end
            end
        end

        // Forced reset takes one cycle and leaves the controller asleep
        n.ctl_rst = 1'b0;
        if (s.ctrl[`CMC_B_FORCED_CONTROLLER_RESET]) begin
            n.ctrl     = `CMC_CTRL_RST; // see R15 see R16 see R04
            n.mode     = CMC_SLEEP;
            n.busoff   = 1'b0;
            n.armed    = 1'b0;
            n.rec_bits = 4'h0;
            n.rec_seqs = 8'h0;
            n.ctl_rst  = 1'b1;
        end

        // Traffic only in normal mode, not bus-off, not frozen by debug
        n.run = (n.mode == CMC_NORMAL) && !n.busoff
              && !(s.ctrl[`CMC_B_FRZ] && dbg_halt); // see R17 see R20
    end

    //------------------------------------------------------------------
    // State register
    //------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s         <= '0;
            s.ctrl    <= `CMC_CTRL_RST; // see R04
            s.mode    <= CMC_SLEEP;
            s.rx_s1   <= 1'b1;
            s.rx_s2   <= 1'b1;
            s.rx_prev <= 1'b1;
            s.awready <= 1'b1;
            s.wready  <= 1'b1;
            s.arready <= 1'b1;
        end else begin
            s <= n;
        end
    end

    //------------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------------
    property p_init_enter;
        @(posedge clk_sys) disable iff (rst)
        (s.ctrl[`CMC_B_INIT] && !s.ctrl[`CMC_B_FORCED_CONTROLLER_RESET]) |=> (s.mode == CMC_INIT);
    endproperty
    a_init_enter: assert property (p_init_enter) else $error("init request not honoured"); // see R01 see R18

    property p_normal;
        @(posedge clk_sys) disable iff (rst)
        (s.ctrl[`CMC_B_SLEEP:`CMC_B_INIT] == 2'h0 && !s.ctrl[`CMC_B_FORCED_CONTROLLER_RESET])
        |=> (s.mode == CMC_NORMAL);
    endproperty
    a_normal: assert property (p_normal) else $error("normal mode not entered"); // see R01 see R02

    property p_sleep;
        @(posedge clk_sys) disable iff (rst)
        (s.ctrl[`CMC_B_SLEEP:`CMC_B_INIT] == 2'h2 && !s.ctrl[`CMC_B_FORCED_CONTROLLER_RESET])
        |=> (s.mode == CMC_SLEEP);
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep mode not entered"); // see R02 see R19

    property p_wake;
        @(posedge clk_sys) disable iff (rst)
        (s.mode == CMC_SLEEP && s.ctrl[`CMC_B_AWAKE] && rx_edge && !wr_ctrl
         && !s.ctrl[`CMC_B_FORCED_CONTROLLER_RESET]) |=> !s.ctrl[`CMC_B_SLEEP] ##1 (s.mode != CMC_SLEEP);
    endproperty
    a_wake: assert property (p_wake) else $error("automatic wake-up missed"); // see R03 see R12

    property p_forced_controller_reset;
        @(posedge clk_sys) disable iff (rst)
        s.ctrl[`CMC_B_FORCED_CONTROLLER_RESET] |=> (s.ctrl == `CMC_CTRL_RST) && (s.mode == CMC_SLEEP) && s.ctl_rst;
    endproperty
    a_forced_controller_reset: assert property (p_forced_controller_reset) else $error("forced reset not applied"); // see R04 see R15 see R16

    property p_busoff;
        @(posedge clk_sys) disable iff (rst)
        (!s.busoff && tec > `CMC_TEC_LIMIT && !s.ctrl[`CMC_B_FORCED_CONTROLLER_RESET]) |=> s.busoff ##1 !s.run;
    endproperty
    a_busoff: assert property (p_busoff) else $error("bus-off not entered"); // see R20

    property p_freeze;
        @(posedge clk_sys) disable iff (rst)
        (s.ctrl[`CMC_B_FRZ] && dbg_halt) |=> !s.run;
    endproperty
    a_freeze: assert property (p_freeze) else $error("debug freeze ignored"); // see R17

    property p_recover;
        @(posedge clk_sys) disable iff (rst)
        ($fell(s.busoff) && !$past(s.ctrl[`CMC_B_FORCED_CONTROLLER_RESET]))
        |-> ($past(s.rec_seqs) == `CMC_REC_SEQS) && ($past(s.ctrl[`CMC_B_ABOFF]) || $past(s.armed));
    endproperty
    a_recover: assert property (p_recover) else $error("bus-off left too early"); // see R13 see R14

    property p_reserved;
        @(posedge clk_sys) disable iff (rst)
        (axi_i.arvalid && s.arready && {axi_i.araddr[`CMC_AW-1:2], 2'b00} == `CMC_CTRL_OFF)
        |=> s.rvalid && ((s.rdata & ~`CMC_CTRL_WMASK) == 32'h0);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved control bits set"); // see R21

    property p_no_count;
        @(posedge clk_sys) disable iff (rst)
        (s.busoff && !s.ctrl[`CMC_B_ABOFF] && !s.armed && !s.ctrl[`CMC_B_FORCED_CONTROLLER_RESET])
        |=> $stable(s.rec_seqs) && $stable(s.rec_bits);
    endproperty
    a_no_count: assert property (p_no_count) else $error("recovery counted before init cycle"); // see R14

    property p_busoff_quiet;
        @(posedge clk_sys) disable iff (rst)
        s.busoff |-> !s.run;
    endproperty
    a_busoff_quiet: assert property (p_busoff_quiet) else $error("traffic allowed in bus-off"); // see R20
endmodule
`default_nettype wire

//--- tb/cmc_bus_node.sv
// Far-side CAN node model: receive line and bit sampling strobes
`timescale 1ns/1ps
`default_nettype none
module cmc_bus_node (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // Commands from the bench
    input  wire logic dom_req,
    input  wire logic strobe_en,
    // Line towards the controller
    output logic      can_rx,
    output logic      bit_strobe
);
    logic [2:0] dom_cnt_r;

    // A short dominant burst stands for a frame start; strobes sample recessive idle bits
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dom_cnt_r  <= 3'h0;
            bit_strobe <= 1'b0;
        end else begin
            dom_cnt_r  <= dom_req ? 3'h4 : ((dom_cnt_r != 3'h0) ? dom_cnt_r - 3'h1 : 3'h0);
            bit_strobe <= strobe_en & ~bit_strobe;
        end
    end

    // Released bus returns to recessive through the bus termination
    assign can_rx = (dom_cnt_r == 3'h0);
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the CAN main mode control block
`timescale 1ns/1ps
`default_nettype none
module testbench
    import cmc_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic            clk_sys;
    logic            rst;
    cmc_axi_req_type axi_i;
    cmc_axi_rsp_type axi_o;
    logic            can_rx;
    logic            bit_strobe;
    logic [8:0]      tec;
    logic            dbg_halt;
    cmc_engine_type  eng_o;
    logic            dom_req;
    logic            strobe_en;
    logic [1:0]      exp_b[$];
    logic [33:0]     exp_r[$];
    int              n_mismatch;
    int              check_count;
    int              cycles;
    int              n_pulse;
    logic [31:0]     seed;
    logic [31:0]     v;

    cmc_top cmc_top_inst (.clk_sys(clk_sys), .rst(rst), .axi_i(axi_i), .axi_o(axi_o), .can_rx(can_rx),
        .bit_strobe(bit_strobe), .tec(tec), .dbg_halt(dbg_halt), .eng_o(eng_o));
    cmc_bus_node cmc_bus_node_inst (.clk_sys(clk_sys), .rst(rst), .dom_req(dom_req),
        .strobe_en(strobe_en), .can_rx(can_rx), .bit_strobe(bit_strobe));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic chk(input logic [33:0] s, input logic [33:0] e);
        check_count++;
        if (s !== e) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic chk1(input logic s, input logic e);
        chk({33'h0, s}, {33'h0, e});
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Address and data go up together and drop once taken; ready lines stay high
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
        exp_b.push_back(e);
        axi_i.awaddr  <= a;
        axi_i.wdata   <= d;
        axi_i.awvalid <= 1'b1;
        axi_i.wvalid  <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (axi_i.awvalid && axi_o.awready) axi_i.awvalid <= 1'b0;
            if (axi_i.wvalid && axi_o.wready) axi_i.wvalid <= 1'b0;
        end while (axi_o.bvalid !== 1'b1);
    endtask

    task automatic rd(input logic [11:0] a, input logic [33:0] e);
        exp_r.push_back(e);
        axi_i.araddr  <= a;
        axi_i.arvalid <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (axi_i.arvalid && axi_o.arready) axi_i.arvalid <= 1'b0;
        end while (axi_o.rvalid !== 1'b1);
    endtask

    // Recessive strobes until bus-off ends; the count of strobes must land in a window
    task automatic recover(input int lo, input int hi);
        int n;
        n = 0;
        strobe_en <= 1'b1;
        while (eng_o.busoff_flag === 1'b1) begin
            @(posedge clk_sys);
            if (bit_strobe) n++;
        end
        strobe_en <= 1'b0;
        chk1(n >= lo && n <= hi, 1'b1);
    endtask

    // ------------------------------------------------------------
    // Clock, watchdog and response monitor
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Longest path is two recovery waits of about 2816 cycles each and one 3000-cycle hold in bus-off
    always @(posedge clk_sys) begin
        cycles++;
        if (eng_o.controller_reset === 1'b1) n_pulse++;
        if (cycles == 20000) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t run did not finish", $time);
            summarize();
        end
    end

    always @(posedge clk_sys) begin
        if (axi_o.bvalid === 1'b1) chk({32'h0, axi_o.bresp}, {32'h0, exp_b.pop_front()});
        if (axi_o.rvalid === 1'b1) chk({axi_o.rresp, axi_o.rdata}, exp_r.pop_front());
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        axi_i = '0;
        axi_i.wstrb = 4'hf;
        axi_i.bready = 1'b1;
        axi_i.rready = 1'b1;
        tec = 9'h0;
        dbg_halt = 1'b0;
        dom_req = 1'b0;
        strobe_en = 1'b0;
        n_mismatch = 0;
        check_count = 0;
        cycles = 0;
        n_pulse = 0;
        seed = 32'hba58;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        chk({31'h0, axi_o.awready, axi_o.wready, axi_o.arready}, 34'h7);
        rd(12'h000, 34'h00010002);
        rd(12'h004, 34'h802);
        chk1(eng_o.run_enable, 1'b0);
        wr(12'h000, 32'h0, 2'b00);
        repeat (3) @(posedge clk_sys);
        rd(12'h004, 34'h800);
        chk1(eng_o.run_enable, 1'b1);
        wr(12'h000, 32'h1, 2'b00);
        rd(12'h004, 34'h801);
        wr(12'h000, 32'h1c, 2'b00);
        chk({31'h0, eng_o.tx_priority_by_order, eng_o.rx_fifo_overrun_lock, eng_o.auto_retransmit_disable},
            34'h7);
        // Random control words; the forced reset bit is kept out of them
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            v = seed & 32'hffff7fff;
            wr(12'h000, v, 2'b00);
            repeat (3) @(posedge clk_sys);
            rd(12'h000, {2'b00, v & 32'h0001007f});
            rd(12'h004, {2'b00, 32'h800 | {30'h0, v[1] & ~v[0], v[0]}});
            chk({31'h0, eng_o.tx_priority_by_order, eng_o.rx_fifo_overrun_lock, eng_o.auto_retransmit_disable},
                {31'h0, v[2], v[3], v[4]});
        end
        wr(12'h000, 32'h22, 2'b00);
        rd(12'h004, 34'h802);
        dom_req <= 1'b1;
        @(posedge clk_sys);
        dom_req <= 1'b0;
        repeat (12) @(posedge clk_sys);
        rd(12'h000, 34'h20);
        rd(12'h004, 34'h800);
        wr(12'h000, 32'h10000, 2'b00);
        dbg_halt <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk1(eng_o.run_enable, 1'b0);
        rd(12'h000, 34'h10000);
        dbg_halt <= 1'b0;
        wr(12'h000, 32'h40, 2'b00);
        tec <= 9'h0ff;
        repeat (3) @(posedge clk_sys);
        chk1(eng_o.busoff_flag, 1'b0);
        chk1(eng_o.run_enable, 1'b1);
        tec <= 9'h100;
        repeat (3) @(posedge clk_sys);
        chk1(eng_o.busoff_flag, 1'b1);
        chk1(eng_o.run_enable, 1'b0);
        rd(12'h040, 34'h00010001);
        tec <= 9'h0;
        recover(1408, 1409);
        wr(12'h000, 32'h0, 2'b00);
        tec <= 9'h100;
        repeat (3) @(posedge clk_sys);
        tec <= 9'h0;
        strobe_en <= 1'b1;
        repeat (3000) @(posedge clk_sys);
        chk1(eng_o.busoff_flag, 1'b1);
        wr(12'h000, 32'h1, 2'b00);
        wr(12'h000, 32'h0, 2'b00);
        recover(1406, 1409);
        n_pulse = 0;
        wr(12'h000, 32'h00008004, 2'b00);
        repeat (3) @(posedge clk_sys);
        chk(34'(n_pulse), 34'h1);
        rd(12'h000, 34'h00010002);
        rd(12'h004, 34'h802);
        rd(12'h100, {2'b10, 32'h0});
        wr(12'h100, 32'h1, 2'b10);
        wr(12'h004, 32'h1, 2'b00);
        rd(12'h000, 34'h00010002);
        repeat (2) @(posedge clk_sys);
        summarize();
    end
endmodule
`default_nettype wire
